/* pse_sup_params.svh */
// Purpose: constants for the port fault supervisor
// Assumes: 10 MHz system clock, 100 us prescaled tick
// Notes: times given in their own unit, cycle counts derived
`ifndef PSE_SUP_PARAMS_SVH
`define PSE_SUP_PARAMS_SVH
`define CLK_HZ            10000000
`define TICK_US           100
`define TICK_CYC          ((`CLK_HZ / 1000000) * `TICK_US)
`define CUT_MS            60
`define CUT_TICKS         ((`CUT_MS * 1000) / `TICK_US)
`define CUT_UP_STEP       16
`define LIM_MS            12
`define LIM_TICKS         ((`LIM_MS * 1000) / `TICK_US)
`define BAD_US            180
`define BAD_CYC           ((`BAD_US * (`CLK_HZ / 1000000)) + 1)
`define START_MS          60
`define START_TICKS       ((`START_MS * 1000) / `TICK_US)
`define DIS_MS            350
`define DIS_TICKS         ((`DIS_MS * 1000) / `TICK_US)
`define ADC_MS            100
`define ADC_TICKS         ((`ADC_MS * 1000) / `TICK_US)
`define AVG_LEN           10
`define LIM_INRUSH_CODE   8'h00
`define SHED_DLY_NS       6500
`define SHED_CYC          ((`SHED_DLY_NS * (`CLK_HZ / 1000000)) / 1000)
`define A_CTRL            12'h000
`define A_EN              12'h004
`define A_PRIO            12'h008
`define A_LIMEN           12'h00c
`define A_DISEN           12'h010
`define A_ACDISEN         12'h014
`define A_POLICE          12'h018
`define A_STAT            12'h01c
`define A_FAULT           12'h200
`define A_VEE             12'h024
`define A_LIMCODE         12'h040
`define A_CUR             12'h080
`define A_VOLT            12'h0c0
`define A_PCMD            12'h100
`define CTRL_SHEDPOL_BIT  0
`define CTRL_AVG_BIT      1
`define CTRL_PEN_BIT      2
`define CTRL_RST          32'h0000_0000
`define F_CUT             0
`define F_LIM             1
`define F_BAD             2
`define F_START           3
`define F_DIS             4
`define F_POL             5
`define F_SHED            6
`endif

/* pse_sup_pkg.sv */
// Purpose: types of the port fault supervisor
// Assumes: nothing
// Notes: fault bits are positions within fault_t
package pse_sup_pkg;
  typedef enum logic [1:0] {port_off, port_inrush, port_on, port_bad} port_state_t;
  typedef logic [7:0]  fault_t;
  typedef logic [11:0] adc_t;
endpackage : pse_sup_pkg

/* pse_port_fault_supervisor.sv */
// Purpose: per-port overload, limit, switch, disconnect and shed supervision
// Assumes: comparator flags and ADC codes arrive asynchronously from the analog side
// Notes: registers on APB, one word each, fault bits write-one-to-clear except the switch bad bit
//
// The register addresses and register access over APB were left to the implementer.
`include "pse_sup_params.svh"

// Overview of operation
// - overload timer counts up over cut threshold, down at one sixteenth rate
// - overload timer at terminal value turns port off, sets overload fault
// - hard current limiting stays active whenever a port is powered
// - hard-limit timer runs only if enabled, counting while over limit
// - enabled hard-limit timer at terminal turns port off, sets limit fault
// - limit timer disabled: overload timer counts during limit and cut events
// - inrush forces 425mA limit code, then host-programmed code applies
// - port turning off restores its limit setting to 425mA code
// - limit setting is an 8-bit code whose meaning depends on resistor
// - switch abnormality beyond 180us sets bad fault, disables a powered port with weak pulldown, blocks turn-on of an off port
// - switch bad fault latched per port, cleared by port or chip reset
// - open switch raises no bad fault, gives start timeout on turn-on
// - current and voltage readback are zero unless port powered
// - current sampled continuously, plain or one-second average every 100ms
// - police on and average over threshold sets overload and police, turns off a port only once it is on, not in inrush
// - disconnect timer counts below minimum current, expiry turns off, sets fault
// - disconnect monitoring skipped when its enable bits are clear
// - legacy AC-disconnect enables select DC disconnect monitoring instead
// - active shed input turns low priority ports off within 6.5us
// - shed turn-off clears detect and class enables of that port
// - shed input polarity register selectable, default active low
// - negative supply measured with 12-bit converter, readable by host
// - start timer runs in inrush, expiry still over limit faults off
module pse_port_fault_supervisor
  import pse_sup_pkg::*;
#(
  parameter int NPORT = 12
) (
  // clock and reset
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_resetn,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic                           pready,
  output logic [31:0]                    prdata,
  output logic                           pslverr,
  // analog comparators, one bit per port
  input  wire logic [NPORT-1:0]          i_over_cut,
  input  wire logic [NPORT-1:0]          i_over_lim,
  input  wire logic [NPORT-1:0]          i_under_min,
  input  wire logic [NPORT-1:0]          i_switch_abn,
  // converters
  input  wire logic [NPORT*12-1:0]       i_cur_adc,
  input  wire logic [NPORT*12-1:0]       i_volt_adc,
  input  wire pse_sup_pkg::adc_t         i_vee_adc,
  // shed pin
  input  wire logic                      i_shed_input,
  // port drive
  output logic [NPORT-1:0]               o_gate_on,
  output logic [NPORT-1:0]               o_limit_active,
  output logic [NPORT-1:0]               o_weak_pulldown,
  output logic [NPORT*8-1:0]             o_limit_code
);

  // synchronisers for the comparator flags, shed pin and supply code
  logic [NPORT-1:0] cut_m, cut_s, lim_m, lim_s, min_m, min_s, abn_m, abn_s;
  logic             shed_m, shed_s;
  logic [11:0]      vee_m, vee_s;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      {cut_m, cut_s, lim_m, lim_s} <= '0;
      {min_m, min_s, abn_m, abn_s} <= '0;
      {shed_m, shed_s}             <= 2'b11;
      {vee_m, vee_s}               <= '0;
    end else begin
      {cut_m, lim_m, min_m, abn_m} <= {i_over_cut, i_over_lim, i_under_min, i_switch_abn};
      {cut_s, lim_s, min_s, abn_s} <= {cut_m, lim_m, min_m, abn_m};
      shed_m <= i_shed_input;
      shed_s <= shed_m;
      vee_m  <= i_vee_adc;
      vee_s  <= vee_m;
    end
  end

  // supply code held only when two settled samples agree
  // a word caught while the converter changes is never shown
  logic [11:0]      vee_t, vee_q;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      vee_t <= 12'h000;
      vee_q <= 12'h000;
    end else begin
      vee_t <= vee_s;
      if (vee_t == vee_s) vee_q <= vee_s;
    end
  end

  // common prescaled tick
  logic [15:0] pre_cnt;
  logic        tick;
  wire         pre_end = (pre_cnt == 16'(`TICK_CYC - 1));
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      pre_cnt <= '0;
      tick    <= 1'b0;
    end else begin
      pre_cnt <= pre_end ? 16'h0000 : pre_cnt + 16'h0001;
      tick    <= pre_end;
    end
  end

  // 100 ms sample strobe
  logic [15:0] adc_cnt;
  wire         adc_upd = tick && (adc_cnt == 16'(`ADC_TICKS - 1));
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) adc_cnt <= '0;
    else if (tick) adc_cnt <= adc_upd ? 16'h0000 : adc_cnt + 16'h0001;
  end

  // software registers
  logic [31:0]      ctrl;
  logic [NPORT-1:0] en_det, en_cls, prio_hi, lim_en, dis_en, acdis_en;
  logic [11:0]      police_thr;
  logic [7:0]       lim_prog [NPORT];
  fault_t           fault [NPORT];
  port_state_t      pstate [NPORT];
  logic [11:0]      cur_rd [NPORT];
  logic [11:0]      volt_rd [NPORT];

  // apb decode
  wire        acc      = psel && penable;
  wire        wr_acc   = acc && pwrite;
  wire        in_lim   = (paddr[11:6] == `A_LIMCODE >> 6) && (paddr[5:2] < 4'(NPORT));
  wire        in_cur   = (paddr[11:6] == `A_CUR >> 6) && (paddr[5:2] < 4'(NPORT));
  wire        in_volt  = (paddr[11:6] == `A_VOLT >> 6) && (paddr[5:2] < 4'(NPORT));
  wire        in_pcmd  = (paddr[11:6] == `A_PCMD >> 6) && (paddr[5:2] < 4'(NPORT));
  wire        in_fault = (paddr[11:6] == `A_FAULT >> 6) && (paddr[5:2] < 4'(NPORT));
  wire [3:0]  pidx     = paddr[5:2];
  wire        shed_act = ctrl[`CTRL_SHEDPOL_BIT] ? shed_s : !shed_s;
  logic [NPORT-1:0] stat_on;
  logic [NPORT-1:0] shed_kill;

  // read mux
  logic [31:0] rd_val;
  logic        rd_ok;
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    if (in_lim)        rd_val = {24'h0, lim_prog[pidx]};
    else if (in_cur)   rd_val = {20'h0, cur_rd[pidx]};
    else if (in_volt)  rd_val = {20'h0, volt_rd[pidx]};
    else if (in_fault) rd_val = {24'h0, fault[pidx]};
    else if (in_pcmd)  rd_val = 32'h0000_0000;
    else begin
      case (paddr)
        `A_CTRL:    rd_val = ctrl;
        `A_EN:      rd_val = 32'({en_cls, en_det});
        `A_PRIO:    rd_val = 32'(prio_hi);
        `A_LIMEN:   rd_val = 32'(lim_en);
        `A_DISEN:   rd_val = 32'(dis_en);
        `A_ACDISEN: rd_val = 32'(acdis_en);
        `A_POLICE:  rd_val = {20'h0, police_thr};
        `A_STAT:    rd_val = 32'(stat_on);
        `A_VEE:     rd_val = {20'h0, vee_q};
        default:    rd_ok  = 1'b0;
      endcase
    end
  end

  // apb answer, one access cycle
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= (psel && !penable && !pwrite) ? rd_val : 32'h0000_0000;
      pslverr <= psel && !penable && !rd_ok;
    end
  end
  wire wr_take = wr_acc && pready && rd_ok;

  // global control registers; shed clears enables
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl       <= `CTRL_RST;
      {en_det, en_cls, prio_hi, lim_en} <= '0;
      dis_en     <= '1;
      acdis_en   <= '0;
      police_thr <= 12'hfff;
    end else begin
      if (wr_take && paddr == `A_CTRL)    ctrl       <= pwdata;
      if (wr_take && paddr == `A_PRIO)    prio_hi    <= pwdata[NPORT-1:0];
      if (wr_take && paddr == `A_LIMEN)   lim_en     <= pwdata[NPORT-1:0];
      if (wr_take && paddr == `A_DISEN)   dis_en     <= pwdata[NPORT-1:0];
      if (wr_take && paddr == `A_ACDISEN) acdis_en   <= pwdata[NPORT-1:0];
      if (wr_take && paddr == `A_POLICE)  police_thr <= pwdata[11:0];
      if (wr_take && paddr == `A_EN) begin
        en_det <= pwdata[NPORT-1:0] & ~shed_kill;
        en_cls <= pwdata[2*NPORT-1:NPORT] & ~shed_kill;
      end else begin
        en_det <= en_det & ~shed_kill;
        en_cls <= en_cls & ~shed_kill;
      end
    end
  end

  // per-port supervision
  genvar p;
  generate
    for (p = 0; p < NPORT; p++) begin : g_port
      logic [15:0] cut_t, lim_t, st_t, dis_t;
      logic [11:0] bad_t;
      logic [3:0]  sub;
      logic [11:0] avg_sum_hi;
      logic [15:0] avg_sum;
      logic [11:0] avg_buf [`AVG_LEN];
      logic [11:0] cur_s1, cur_s2, volt_s1, volt_s2, avg_val;
      logic [11:0] cur_s3, volt_s3, cur_q, volt_q;
      wire  powered   = (pstate[p] == port_on) || (pstate[p] == port_inrush);
      wire  cmd_on    = wr_take && in_pcmd && pidx == 4'(p) && pwdata[0];
      wire  cmd_off   = wr_take && in_pcmd && pidx == 4'(p) && !pwdata[0];
      wire  cmd_rst   = wr_take && in_pcmd && pidx == 4'(p) && pwdata[1];
      wire  clr_w     = wr_take && in_fault && pidx == 4'(p);
      wire  cut_src   = cut_s[p] || (!lim_en[p] && lim_s[p]);
      wire  cut_exp   = cut_t >= 16'(`CUT_TICKS * `CUT_UP_STEP);
      wire  lim_exp   = lim_en[p] && lim_t >= 16'(`LIM_TICKS);
      wire  st_exp    = pstate[p] == port_inrush && st_t >= 16'(`START_TICKS);
      wire  st_fail   = st_exp && (lim_s[p] || min_s[p]);
      wire  dis_mon   = dis_en[p] || acdis_en[p];
      wire  dis_exp   = dis_mon && dis_t >= 16'(`DIS_TICKS);
      wire  pol_hit   = ctrl[`CTRL_PEN_BIT] && adc_upd && avg_val > police_thr;
      wire  bad_hit   = bad_t >= 12'(`BAD_CYC);
      wire  shed_hit  = shed_act && !prio_hi[p] && powered;
      wire  on_trip   = pstate[p] == port_on && (cut_exp || lim_exp || dis_exp || pol_hit);
      wire  in_trip   = pstate[p] == port_inrush && (cut_exp || lim_exp || st_fail);
      fault_t set_f;
      assign set_f = {1'b0, shed_hit, pol_hit && powered, dis_exp && pstate[p] == port_on,
                      st_fail, bad_hit && pstate[p] != port_bad,
                      lim_exp && powered, (cut_exp || pol_hit) && powered};
      assign shed_kill[p] = shed_hit;
      assign stat_on[p]   = powered;
      assign avg_sum_hi   = 12'(avg_sum / 16'(`AVG_LEN));
      assign avg_val      = avg_sum_hi;

      // port state and timers, timed on the shared tick except the switch timer, which counts clock cycles
      always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
          pstate[p] <= port_off;
          {cut_t, lim_t, st_t, dis_t} <= '0;
          bad_t <= '0;
        end else begin
          bad_t <= (abn_s[p] && pstate[p] != port_bad) ? (bad_hit ? bad_t : bad_t + 12'h001) : 12'h000;
          if (tick && powered) begin
            cut_t <= cut_src ? cut_t + 16'(`CUT_UP_STEP) : (cut_t != 0 ? cut_t - 16'h0001 : 16'h0);
            lim_t <= (lim_en[p] && lim_s[p]) ? lim_t + 16'h0001 : 16'h0000;
            st_t  <= (pstate[p] == port_inrush) ? st_t + 16'h0001 : 16'h0000;
            dis_t <= (dis_mon && min_s[p] && pstate[p] == port_on) ? dis_t + 16'h0001 : 16'h0000;
          end
          case (pstate[p])
            port_off:    if (cmd_on && !bad_hit) pstate[p] <= port_inrush;
            port_inrush: if (bad_hit) pstate[p] <= port_bad;
                         else if (cmd_off || in_trip || shed_hit) pstate[p] <= port_off;
                         else if (st_exp) pstate[p] <= port_on;
            port_on:     if (bad_hit) pstate[p] <= port_bad;
                         else if (cmd_off || on_trip || shed_hit) pstate[p] <= port_off;
            port_bad:    if (cmd_rst) pstate[p] <= port_off;
            default:     pstate[p] <= port_off;
          endcase
          if (pstate[p] == port_off || pstate[p] == port_bad) begin
            {cut_t, lim_t, st_t, dis_t} <= '0;
          end
        end
      end

      // fault flags: a set wins over a write-one clear
      always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) fault[p] <= '0;
        else if (cmd_rst) fault[p] <= set_f & ~fault_t'(1 << `F_BAD);
        else fault[p] <= (fault[p] & ~(clr_w ? pwdata[7:0] & ~fault_t'(1 << `F_BAD) : 8'h00)) | set_f;
      end

      // limit code: host writes taken while powered, inrush included, restored at turn-off
      always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) lim_prog[p] <= `LIM_INRUSH_CODE;
        else if (!powered) lim_prog[p] <= `LIM_INRUSH_CODE;
        else if (wr_take && in_lim && pidx == 4'(p)) lim_prog[p] <= pwdata[7:0];
      end

      // converter words held only when two settled samples agree
      // avoids averaging a code torn across the clock boundary
      always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
          {cur_s3, volt_s3, cur_q, volt_q} <= '0;
        end else begin
          cur_s3  <= cur_s2;
          volt_s3 <= volt_s2;
          if (cur_s3 == cur_s2) cur_q <= cur_s2;
          if (volt_s3 == volt_s2) volt_q <= volt_s2;
        end
      end

      // readback, converters and moving average
      always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
          {cur_s1, cur_s2, volt_s1, volt_s2} <= '0;
          avg_sum <= '0;
          for (int k = 0; k < `AVG_LEN; k++) avg_buf[k] <= '0;
          cur_rd[p]  <= '0;
          volt_rd[p] <= '0;
        end else begin
          cur_s1  <= i_cur_adc[p*12 +: 12];
          cur_s2  <= cur_s1;
          volt_s1 <= i_volt_adc[p*12 +: 12];
          volt_s2 <= volt_s1;
          if (!powered) begin
            cur_rd[p]  <= '0;
            volt_rd[p] <= '0;
            avg_sum    <= '0;
            for (int k = 0; k < `AVG_LEN; k++) avg_buf[k] <= '0;
          end else if (adc_upd) begin
            avg_sum <= avg_sum + 16'(cur_q) - 16'(avg_buf[`AVG_LEN-1]);
            avg_buf[0] <= cur_q;
            for (int k = 1; k < `AVG_LEN; k++) avg_buf[k] <= avg_buf[k-1];
            cur_rd[p]  <= ctrl[`CTRL_AVG_BIT] ? 12'((avg_sum + 16'(cur_q) - 16'(avg_buf[`AVG_LEN-1])) / 16'(`AVG_LEN)) : cur_q;
            volt_rd[p] <= volt_q;
          end
        end
      end

      // gate drive outputs
      always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
          o_gate_on[p]          <= 1'b0;
          o_limit_active[p]     <= 1'b0;
          o_weak_pulldown[p]    <= 1'b0;
          o_limit_code[p*8 +: 8] <= `LIM_INRUSH_CODE;
        end else begin
          o_gate_on[p]          <= powered && !bad_hit && !shed_hit;
          o_limit_active[p]     <= powered;
          o_weak_pulldown[p]    <= pstate[p] == port_bad;
          o_limit_code[p*8 +: 8] <= (pstate[p] == port_on) ? lim_prog[p] : `LIM_INRUSH_CODE;
        end
      end
    end
  endgenerate

endmodule : pse_port_fault_supervisor

/* pse_sup_chk_sva.sv */
// Purpose: port-level assertions for the fault supervisor
// Assumes: shed polarity and priority mirrored from apb writes
// Notes: watches port 0 for the switch fault timing
module pse_sup_chk #(
  parameter int NPORT = 12
) (
  // clock, reset and apb
  input wire logic               i_clk_sys,
  input wire logic               i_resetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic               pready,
  input wire logic               pslverr,
  // pins and port drive
  input wire logic [NPORT-1:0]   i_switch_abn,
  input wire logic               i_shed_input,
  input wire logic [NPORT-1:0]   o_gate_on,
  input wire logic [NPORT-1:0]   o_limit_active,
  input wire logic [NPORT-1:0]   o_weak_pulldown,
  input wire logic [NPORT*8-1:0] o_limit_code
);
  timeunit 1ns;
  timeprecision 1ns;
  logic             wr_ok;
  logic             shed_act;
  logic             shed_pol;
  logic [NPORT-1:0] prio_q;
  logic [11:0]      abn_cnt;
  // completed writes and the effective shed level
  assign wr_ok    = psel & penable & pready & pwrite;
  assign shed_act = i_shed_input ~^ shed_pol;
  // mirror of polarity, priority and abnormal-switch duration
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      shed_pol <= 1'b0;
      prio_q   <= '0;
      abn_cnt  <= 12'h000;
    end else begin
      if (wr_ok && paddr == 12'h000) shed_pol <= pwdata[0];
      if (wr_ok && paddr == 12'h008) prio_q <= pwdata[NPORT-1:0];
      abn_cnt <= i_switch_abn[0] ? abn_cnt + 12'h001 : 12'h000;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  setup_ready_a: assert property (psel && !penable |=> pready) else $error("no answer after setup");
  err_ready_a: assert property (pslverr |-> pready && psel && penable) else $error("stray error response");
  limit_active_a: assert property ((o_gate_on & ~o_limit_active) == '0)
    else $error("powered port without limiting");
  weak_gate_a: assert property ((o_weak_pulldown & o_gate_on) == '0)
    else $error("bad port still driven");
  shed_low_a: assert property ($rose(shed_act) |-> ##6 (o_gate_on & ~prio_q) == '0)
    else $error("low priority port not shed");
  shed_high_a: assert property ($rose(shed_act) |-> ##6 (o_gate_on & prio_q) == ($past(o_gate_on, 6) & prio_q))
    else $error("high priority port disturbed");
  bad_early_a: assert property ($rose(o_weak_pulldown[0]) |-> abn_cnt >= 12'h708 && abn_cnt <= 12'h712)
    else $error("switch fault qualified at wrong time");
  bad_late_a: assert property (abn_cnt == 12'h712 |-> o_weak_pulldown[0])
    else $error("switch fault not raised");
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    inrush_code_a: assert property ($rose(o_gate_on[p]) |-> o_limit_code[p*8+:8] == 8'h00)
      else $error("inrush limit code wrong");
    off_code_a: assert property ($fell(o_gate_on[p]) |-> ##[0:1] o_limit_code[p*8+:8] == 8'h00)
      else $error("limit code not restored");
  end
endmodule : pse_sup_chk

bind pse_port_fault_supervisor pse_sup_chk #(.NPORT(NPORT)) pse_sup_chk_inst (
  .i_clk_sys, .i_resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .i_switch_abn, .i_shed_input, .o_gate_on, .o_limit_active, .o_weak_pulldown, .o_limit_code);

/* pd_load_model.sv */
// Purpose: powered load seen through the switch and sense resistor
// Assumes: comparators and converters follow the gate at once
// Notes: unpowered converters show noise, never zero
module pd_load_model #(
  parameter int NPORT = 12
) (
  // gate drive and scenario controls
  input  wire logic [NPORT-1:0]    i_gate_on,
  input  wire logic [NPORT-1:0]    i_heavy,
  input  wire logic [NPORT-1:0]    i_switch_short,
  // comparator levels
  output logic [NPORT-1:0]         o_over_cut,
  output logic [NPORT-1:0]         o_over_lim,
  output logic [NPORT-1:0]         o_under_min,
  output logic [NPORT-1:0]         o_switch_abn,
  // converter codes
  output logic [NPORT*12-1:0]      o_cur_adc,
  output logic [NPORT*12-1:0]      o_volt_adc
);
  timeunit 1ns;
  timeprecision 1ns;
  // load draws current only through a driven gate
  always_comb begin
    o_over_cut   = i_gate_on & i_heavy;
    o_over_lim   = i_gate_on & i_heavy;
    o_under_min  = ~i_gate_on;
    o_switch_abn = i_switch_short;
    for (int p = 0; p < NPORT; p++) begin
      o_cur_adc[p*12+:12]  = i_gate_on[p] ? 12'h3c0 : 12'h5a5;
      o_volt_adc[p*12+:12] = i_gate_on[p] ? 12'h7d0 : 12'ha5a;
    end
  end
endmodule : pd_load_model

/* tb_pse_port_fault_supervisor.sv */
// Purpose: register-level bench for the fault supervisor
// Assumes: load model on the far side, 10 MHz clock
// Notes: millisecond trip timers lie beyond the run length
`include "pse_sup_params.svh"
module tb_pse_port_fault_supervisor;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NP = 12;
  logic             i_clk_sys = 1'b0;
  logic             i_resetn = 1'b0;
  logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]      paddr = 12'h000;
  logic [31:0]      pwdata = 32'h0, prdata, q;
  logic             pready, pslverr, err, i_shed_input = 1'b1;
  logic [NP-1:0]    i_over_cut, i_over_lim, i_under_min, i_switch_abn;
  logic [NP-1:0]    o_gate_on, o_limit_active, o_weak_pulldown;
  logic [NP-1:0]    heavy = '0, short_req = '0;
  logic [NP*12-1:0] i_cur_adc, i_volt_adc;
  logic [NP*8-1:0]  o_limit_code;
  logic [11:0]      i_vee_adc = 12'h9c4;
  int               err_count = 0, n_tests = 0, cyc = 0;

  pse_port_fault_supervisor #(.NPORT(NP)) pse_port_fault_supervisor_inst (
    .i_clk_sys, .i_resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .i_over_cut, .i_over_lim, .i_under_min, .i_switch_abn, .i_cur_adc, .i_volt_adc, .i_vee_adc,
    .i_shed_input, .o_gate_on, .o_limit_active, .o_weak_pulldown, .o_limit_code);

  pd_load_model #(.NPORT(NP)) pd_load_model_inst (
    .i_gate_on(o_gate_on), .i_heavy(heavy), .i_switch_short(short_req), .o_over_cut(i_over_cut),
    .o_over_lim(i_over_lim), .o_under_min(i_under_min), .o_switch_abn(i_switch_abn),
    .o_cur_adc(i_cur_adc), .o_volt_adc(i_volt_adc));

  // clock and hang guard
  always #50 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge i_clk_sys);
    penable <= 1'b1;
    do @(posedge i_clk_sys); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rdc

  task automatic tally_and_finish();
    if (err_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    // reset values, idle readback, unmapped place
    rdc(`A_CTRL, `CTRL_RST);
    rdc(`A_DISEN, 32'h0000_0fff);
    rdc(`A_ACDISEN, 32'h0);
    rdc(`A_POLICE, 32'h0000_0fff);
    rdc(`A_CUR, 32'h0);
    rdc(`A_VOLT + 12'h004, 32'h0);
    rdc(`A_VEE, 32'h0000_09c4);
    apb(1'b1, 12'hffc, 32'hffff_ffff);
    chk({31'h0, err}, 32'h1);
    rdc(12'hffc, 32'h0);
    // ports 0..2 on, port 1 high priority, code written in inrush
    apb(1'b1, `A_PRIO, 32'h2);
    apb(1'b1, `A_EN, 32'h00ff_ffff);
    for (int p = 0; p < 3; p++) apb(1'b1, `A_PCMD + 12'(4 * p), 32'h1);
    apb(1'b1, `A_LIMCODE, 32'h80);
    rdc(`A_LIMCODE, 32'h80);
    repeat (2) @(posedge i_clk_sys);
    chk({29'h0, o_gate_on[2:0]}, 32'h7);
    chk({29'h0, o_limit_active[2:0]}, 32'h7);
    chk({24'h0, o_limit_code[7:0]}, `LIM_INRUSH_CODE);
    // default active-low shed
    i_shed_input <= 1'b0;
    repeat (65) @(posedge i_clk_sys);
    chk({29'h0, o_gate_on[2:0]}, 32'h2);
    rdc(`A_EN, 32'h00ff_affa);
    rdc(`A_LIMCODE, 32'h0);
    rdc(`A_STAT, 32'h2);
    i_shed_input <= 1'b1;
    // active-high shed selected while the pin idles high
    apb(1'b1, `A_EN, 32'h00ff_ffff);
    apb(1'b1, `A_PCMD + 12'h008, 32'h1);
    repeat (2) @(posedge i_clk_sys);
    chk({29'h0, o_gate_on[2:0]}, 32'h6);
    apb(1'b1, `A_CTRL, 32'h7);
    repeat (65) @(posedge i_clk_sys);
    chk({29'h0, o_gate_on[2:0]}, 32'h2);
    rdc(`A_CTRL, 32'h7);
    i_shed_input <= 1'b0;
    // switch fault on port 0 beside powered port 1
    apb(1'b1, `A_EN, 32'h00ff_ffff);
    apb(1'b1, `A_FAULT, 32'hff);
    apb(1'b1, `A_PCMD, 32'h1);
    short_req[0] <= 1'b1;
    repeat (1795) @(posedge i_clk_sys);
    chk({31'h0, o_weak_pulldown[0]}, 32'h0);
    repeat (20) @(posedge i_clk_sys);
    chk({31'h0, o_weak_pulldown[0]}, 32'h1);
    chk({30'h0, o_gate_on[1:0]}, 32'h2);
    apb(1'b1, `A_FAULT, 32'h4);
    rdc(`A_FAULT, 32'h4);
    short_req[0] <= 1'b0;
    apb(1'b1, `A_PCMD, 32'h2);
    rdc(`A_FAULT, 32'h0);
    chk({31'h0, o_weak_pulldown[0]}, 32'h0);
    tally_and_finish();
  end
endmodule : tb_pse_port_fault_supervisor
